//--- common/acof_consts.vh
/*
 Constants for the cell output port framing block.
 Assumes inclusion by bare name from rtl files; definitions only.
*/
`ifndef ACOF_CONSTS_VH
`define ACOF_CONSTS_VH
// ----------------------------------------
// Geometry
// ----------------------------------------
`define ACOF_NPORTS 8
`define ACOF_NIB_W 4
`define ACOF_SEL_W 3
`define ACOF_CNT_W 7
// ----------------------------------------
// Cell layout in nibbles
// ----------------------------------------
`define ACOF_CELL_NIBS 7'h6C
`define ACOF_DUMMY_FIRST 7'h10
`define ACOF_DUMMY_LAST 7'h11
`define ACOF_CNT_ZERO 7'h00
`define ACOF_CNT_ONE 7'h01
// ----------------------------------------
// Port states
// ----------------------------------------
`define ACOF_ST_IDLE 2'h0
`define ACOF_ST_FRAME 2'h1
`define ACOF_ST_DATA 2'h2
`endif

//--- rtl/acof_output_framer.v
/*
 Output side framing of a cell switching memory: eight nibble ports.
 Assumes cell data is presented per port with a valid/taken handshake on clk.
*/
// Summary of operation
// - Nibble data and frame launched on the rising edge of the port clock.
// - Every port clock is independent and synchronised separately.
// - A stopped port clock pauses the cell; it resumes without loss.
// - Frame goes high one port clock before the first nibble.
// - A sensed high frame reloads the nibble counter with the start address.
// - In cell bus mode frame lines one to seven become arbitration lines.
// - Eight four-bit data ports, bit three is the most significant.
// - Each nibble port is mapped to a chosen clock and frame.
// - Nibble ports may be grouped into wider ports sharing one clock.
// - Control outputs driven only with both pins and config bit low.
// - Add-byte affects only the input side; ignored by this block.
// - Strip-byte removes the dummy ninth byte before output.
// - Output enable pin high releases every output.
`timescale 1ns/1ps
`include "acof_consts.vh"
module acof_output_framer #(
    parameter NPORTS = `ACOF_NPORTS
) (
    clk,
    rst,
    out_port_clock,
    out_cell_start_in,
    out_cell_start_out,
    out_cell_start_oe,
    out_port_nibble,
    out_port_nibble_oe,
    port_map,
    start_byte_addr,
    cell_valid,
    cell_data,
    cell_taken,
    nib_addr,
    cell_bus_mode,
    cell_bus_arbitration_out,
    cell_bus_arbitration_in,
    cell_bus_arbitration_oe,
    output_enable_n,
    control_output_enable_n,
    control_enable_cfg,
    control_outputs_oe,
    add_dummy_byte,
    strip_dummy_byte
);
    input wire clk;
    input wire rst;
    input wire [NPORTS-1:0] out_port_clock;
    input wire [NPORTS-1:0] out_cell_start_in;
    output reg [NPORTS-1:0] out_cell_start_out;
    output reg [NPORTS-1:0] out_cell_start_oe;
    output reg [NPORTS*`ACOF_NIB_W-1:0] out_port_nibble;
    output reg [NPORTS-1:0] out_port_nibble_oe;
    input wire [NPORTS*`ACOF_SEL_W-1:0] port_map;
    input wire [`ACOF_CNT_W-1:0] start_byte_addr;
    input wire [NPORTS-1:0] cell_valid;
    input wire [NPORTS*`ACOF_NIB_W-1:0] cell_data;
    output reg [NPORTS-1:0] cell_taken;
    output reg [NPORTS*`ACOF_CNT_W-1:0] nib_addr;
    input wire cell_bus_mode;
    input wire [NPORTS-1:1] cell_bus_arbitration_out;
    output reg [NPORTS-1:1] cell_bus_arbitration_in;
    output reg [NPORTS-1:1] cell_bus_arbitration_oe;
    input wire output_enable_n;
    input wire control_output_enable_n;
    input wire control_enable_cfg;
    output reg control_outputs_oe;
    input wire add_dummy_byte;
    input wire strip_dummy_byte;

    reg [1:0] oe_n_q;
    reg [1:0] ctl_n_q;
    reg [1:0] strip_q;
    reg [1:0] cbm_q;
    reg [NPORTS-1:0] lead;
    reg [NPORTS*`ACOF_SEL_W-1:0] map_q;
    wire [NPORTS*`ACOF_NIB_W-1:0] lane_nib;
    wire [NPORTS-1:0] lane_frm;
    wire [NPORTS-1:0] lane_frm_oe;
    wire [NPORTS-1:0] lane_taken;
    wire [NPORTS*`ACOF_CNT_W-1:0] lane_addr;
    wire [NPORTS-1:0] lane_frame_in;
    reg [NPORTS*`ACOF_NIB_W-1:0] mapped_nib;
    wire outs_on;
    integer i;
    integer j;
    genvar g;

    // ----------------------------------------
    // Static pin synchronisers
    // ----------------------------------------
    // Add-byte acts on the input side only, so it is left unread here
    always @(posedge clk) begin
        if (rst) begin
            oe_n_q <= 2'h3;
            ctl_n_q <= 2'h3;
            strip_q <= 2'h0;
            cbm_q <= 2'h0;
            map_q <= {NPORTS*`ACOF_SEL_W{1'b0}};
        end else begin
            oe_n_q <= {oe_n_q[0], output_enable_n};
            ctl_n_q <= {ctl_n_q[0], control_output_enable_n};
            strip_q <= {strip_q[0], strip_dummy_byte};
            cbm_q <= {cbm_q[0], cell_bus_mode};
            map_q <= port_map;
        end
    end
    assign outs_on = ~oe_n_q[1];

    // ----------------------------------------
    // Lead lanes: a nibble port mapped to its own clock runs a sequencer
    // ----------------------------------------
    // ----------------------------------------
    // Grouped ports copy the nibble of the lane they are mapped to
    // ----------------------------------------
    // Separate loop variable keeps the clocked loop free of a second driver
    always @* begin
        lead = {NPORTS{1'b0}};
        mapped_nib = {NPORTS*`ACOF_NIB_W{1'b0}};
        for (j = 0; j < NPORTS; j = j + 1) begin
            lead[j] = (map_q[j*`ACOF_SEL_W +: `ACOF_SEL_W] == j[`ACOF_SEL_W-1:0]);
            mapped_nib[j*`ACOF_NIB_W +: `ACOF_NIB_W] =
                lane_nib[map_q[j*`ACOF_SEL_W +: `ACOF_SEL_W]*`ACOF_NIB_W +: `ACOF_NIB_W];
        end
    end

    generate
        for (g = 0; g < NPORTS; g = g + 1) begin : lane
            // Frame lines one to seven in cell bus mode belong to arbitration, not framing
            if (g == 0) begin : f0
                assign lane_frame_in[g] = out_cell_start_in[g];
            end else begin : fn
                assign lane_frame_in[g] = out_cell_start_in[g] & ~cbm_q[1];
            end
            acof_port_lane u_lane (
                .clk(clk),
                .rst(rst),
                .link_clk(out_port_clock[g]),
                .frame_in(lane_frame_in[g]),
                .cell_valid(cell_valid[g]),
                .cell_nibble(cell_data[g*`ACOF_NIB_W +: `ACOF_NIB_W]),
                .strip_en(strip_q[1]),
                .start_addr(start_byte_addr),
                .nib_addr(lane_addr[g*`ACOF_CNT_W +: `ACOF_CNT_W]),
                .cell_taken(lane_taken[g]),
                .nibble_q(lane_nib[g*`ACOF_NIB_W +: `ACOF_NIB_W]),
                .frame_out_q(lane_frm[g]),
                .frame_oe_q(lane_frm_oe[g]),
                .link_rise()
            );
        end
    endgenerate

    // ----------------------------------------
    // Output registers and enables
    // ----------------------------------------
    // Grouped ports take the sequencer of their mapped lead, so one
    // cell source feeds a wider port; group members share its timing.
    always @(posedge clk) begin
        if (rst) begin
            out_cell_start_out <= {NPORTS{1'b0}};
            out_cell_start_oe <= {NPORTS{1'b0}};
            out_port_nibble <= {NPORTS*`ACOF_NIB_W{1'b0}};
            out_port_nibble_oe <= {NPORTS{1'b0}};
            cell_taken <= {NPORTS{1'b0}};
            nib_addr <= {NPORTS*`ACOF_CNT_W{1'b0}};
            cell_bus_arbitration_in <= {(NPORTS-1){1'b0}};
            cell_bus_arbitration_oe <= {(NPORTS-1){1'b0}};
            control_outputs_oe <= 1'b0;
        end else begin
            for (i = 0; i < NPORTS; i = i + 1) begin
                out_port_nibble[i*`ACOF_NIB_W +: `ACOF_NIB_W] <=
                    mapped_nib[i*`ACOF_NIB_W +: `ACOF_NIB_W];
                out_port_nibble_oe[i] <= outs_on;
                cell_taken[i] <= lane_taken[i] & lead[i];
                nib_addr[i*`ACOF_CNT_W +: `ACOF_CNT_W] <= lane_addr[i*`ACOF_CNT_W +: `ACOF_CNT_W];
                if (i != 0 && cbm_q[1]) begin
                    out_cell_start_out[i] <= cell_bus_arbitration_out[i];
                    out_cell_start_oe[i] <= outs_on & cell_bus_arbitration_out[i];
                end else begin
                    out_cell_start_out[i] <= lane_frm[i];
                    out_cell_start_oe[i] <= outs_on & lane_frm_oe[i] & lead[i];
                end
            end
            cell_bus_arbitration_in <= out_cell_start_in[NPORTS-1:1];
            cell_bus_arbitration_oe <= out_cell_start_oe[NPORTS-1:1];
            control_outputs_oe <= outs_on & ~ctl_n_q[1] & ~control_enable_cfg;
        end
    end
endmodule // acof_output_framer

//--- rtl/acof_port_lane.v
/*
 One output lane: synchronises its link clock, frames and shifts out a cell.
 Assumes the cell source holds cell_nibble stable for the addressed nibble.
*/
`timescale 1ns/1ps
`include "acof_consts.vh"
module acof_port_lane (
    clk,
    rst,
    link_clk,
    frame_in,
    cell_valid,
    cell_nibble,
    strip_en,
    start_addr,
    nib_addr,
    cell_taken,
    nibble_q,
    frame_out_q,
    frame_oe_q,
    link_rise
);
    input wire clk;
    input wire rst;
    input wire link_clk;
    input wire frame_in;
    input wire cell_valid;
    input wire [`ACOF_NIB_W-1:0] cell_nibble;
    input wire strip_en;
    input wire [`ACOF_CNT_W-1:0] start_addr;
    output wire [`ACOF_CNT_W-1:0] nib_addr;
    output reg cell_taken;
    output reg [`ACOF_NIB_W-1:0] nibble_q;
    output reg frame_out_q;
    output reg frame_oe_q;
    output wire link_rise;

    reg [2:0] lclk_q;
    reg [1:0] frm_q;
    reg [1:0] st_q;
    reg [`ACOF_CNT_W-1:0] cnt_q;
    wire frame_seen;
    wire [`ACOF_CNT_W-1:0] cnt_inc;

    // ----------------------------------------
    // Synchronisers and edge finding
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            lclk_q <= 3'h0;
            frm_q <= 2'h0;
        end else begin
            lclk_q <= {lclk_q[1:0], link_clk};
            frm_q <= {frm_q[0], frame_in};
        end
    end
    assign link_rise = lclk_q[1] & ~lclk_q[2];
    // Own drive is excluded so only another device realigns us
    assign frame_seen = frm_q[1] & ~frame_oe_q;
    assign nib_addr = cnt_q;
    // Skip the dummy byte ahead of time so every link edge still emits a nibble
    assign cnt_inc = (strip_en && (cnt_q + `ACOF_CNT_ONE == `ACOF_DUMMY_FIRST)) ?
                     (`ACOF_DUMMY_LAST + `ACOF_CNT_ONE) : (cnt_q + `ACOF_CNT_ONE);

    // ----------------------------------------
    // Cell sequencer, advanced only on link edges
    // ----------------------------------------
    always @(posedge clk) begin
        if (rst) begin
            st_q <= `ACOF_ST_IDLE;
            cnt_q <= `ACOF_CNT_ZERO;
            cell_taken <= 1'b0;
            nibble_q <= 4'h0;
            frame_out_q <= 1'b0;
            frame_oe_q <= 1'b0;
        end else begin
            cell_taken <= 1'b0;
            if (link_rise) begin
                case (st_q)
                `ACOF_ST_IDLE: begin
                    nibble_q <= 4'h0;
                    frame_out_q <= 1'b0;
                    frame_oe_q <= 1'b0;
                    if (frame_seen) begin
                        cnt_q <= start_addr;
                    end else if (cell_valid) begin
                        frame_out_q <= 1'b1;
                        frame_oe_q <= 1'b1;
                        cnt_q <= start_addr;
                        st_q <= `ACOF_ST_FRAME;
                    end
                end
                `ACOF_ST_FRAME, `ACOF_ST_DATA: begin
                    frame_out_q <= 1'b0;
                    frame_oe_q <= 1'b0;
                    st_q <= `ACOF_ST_DATA;
                    if (frame_seen) begin
                        cnt_q <= start_addr;
                    end else begin
                        nibble_q <= cell_nibble;
                        if (cnt_q == `ACOF_CELL_NIBS - `ACOF_CNT_ONE) begin
                            cnt_q <= `ACOF_CNT_ZERO;
                            cell_taken <= 1'b1;
                            st_q <= `ACOF_ST_IDLE;
                        end else begin
                            cnt_q <= cnt_inc;
                        end
                    end
                end
                default: begin
                    st_q <= `ACOF_ST_IDLE;
                end
                endcase
            end
        end
    end
endmodule // acof_port_lane

//--- tb/acof_cell_sink.sv
/* Downstream cell receiver for one lane.
 Assumes the bench sets want and clears got before each cell. */
`timescale 1ns/1ps
module acof_cell_sink (
    input wire run,
    input wire frame,
    input wire [3:0] nibble,
    output logic link_clk
);
    // ----
    // Own clock, odd phase offset from clk
    // ----
    logic [3:0] got[$];
    int want = 0;
    logic busy = 1'b0;
    initial begin
        link_clk = 1'b0;
        #173;
        forever #400 if (run) link_clk = ~link_clk;
    end
    always @(posedge link_clk) begin
        if (busy) begin
            got.push_back(nibble);
            if (got.size() >= want) busy = 1'b0;
        end else if (frame && want > 0 && got.size() == 0) begin
            busy = 1'b1;
        end
    end
endmodule // acof_cell_sink

//--- tb/acof_framer_props.sv
/* Port checker for the output framer.
 Assumes one clk domain, enables seen through a short sync pipeline. */
`timescale 1ns/1ps
module acof_framer_props #(parameter NPORTS = 8) (
    input wire clk,
    input wire rst,
    input wire output_enable_n,
    input wire control_output_enable_n,
    input wire control_enable_cfg,
    input wire control_outputs_oe,
    input wire [NPORTS-1:0] out_port_nibble_oe,
    input wire [NPORTS-1:0] out_cell_start_out,
    input wire [NPORTS-1:0] out_cell_start_oe,
    input wire [NPORTS*4-1:0] out_port_nibble,
    input wire [NPORTS-1:0] cell_taken
);
    // ----
    // Five cycles covers sync plus output register
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_all_on; !output_enable_n && !control_output_enable_n && !control_enable_cfg; endsequence
    sequence s_frame_up; $rose(out_cell_start_out[0]); endsequence
    property p_oe_data; output_enable_n [*5] |-> out_port_nibble_oe == '0; endproperty
    a_oe_data: assert property (p_oe_data) else $error("data driven while disabled");
    property p_oe_frame; output_enable_n [*5] |-> out_cell_start_oe == '0; endproperty
    a_oe_frame: assert property (p_oe_frame) else $error("frame driven while disabled");
    property p_data_on; (!output_enable_n) [*5] |-> out_port_nibble_oe == '1; endproperty
    a_data_on: assert property (p_data_on) else $error("data not driven");
    property p_ctl_pin; control_output_enable_n [*5] |-> !control_outputs_oe; endproperty
    a_ctl_pin: assert property (p_ctl_pin) else $error("control on with pin high");
    property p_ctl_cfg; control_enable_cfg [*5] |-> !control_outputs_oe; endproperty
    a_ctl_cfg: assert property (p_ctl_cfg) else $error("control on with bit high");
    property p_ctl_on; s_all_on [*5] |-> control_outputs_oe; endproperty
    a_ctl_on: assert property (p_ctl_on) else $error("control off with all low");
    property p_frame_hold; s_frame_up |-> out_cell_start_out[0] [*6]; endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame too short");
    property p_nib_hold; $changed(out_port_nibble[3:0]) |=> $stable(out_port_nibble[3:0]) [*5];
    endproperty
    a_nib_hold: assert property (p_nib_hold) else $error("nibble off link clock");
    property p_taken_once; cell_taken[0] |=> (!cell_taken[0]) [*8]; endproperty
    a_taken_once: assert property (p_taken_once) else $error("cell end repeated");
endmodule // acof_framer_props
bind acof_output_framer acof_framer_props #(.NPORTS(NPORTS)) i_props (
    .clk(clk), .rst(rst), .output_enable_n(output_enable_n),
    .control_output_enable_n(control_output_enable_n), .control_enable_cfg(control_enable_cfg),
    .control_outputs_oe(control_outputs_oe), .out_port_nibble_oe(out_port_nibble_oe),
    .out_cell_start_out(out_cell_start_out), .out_cell_start_oe(out_cell_start_oe),
    .out_port_nibble(out_port_nibble), .cell_taken(cell_taken));

//--- tb/test_acof_output_framer.sv
/* Self-checking bench for the output framer.
 Assumes a pull-down on frame lines and lane 0 as the traffic lane. */
`timescale 1ns/1ps
module test_acof_output_framer;
    // ----
    // Stimulus and model
    // ----
    logic clk = 1'b0, rst = 1'b1, run = 1'b0, link0;
    logic oe_n = 1'b1, ctl_n = 1'b1, cfg = 1'b1, strip = 1'b0, add = 1'b0;
    logic [7:0] cv = 8'h00, fr_out, fr_oe, taken, nib_oe;
    logic [31:0] nib, key = 32'h0000_0000;
    logic [55:0] naddr;
    logic ctl_oe;
    int seed = 32'hc791;
    int mismatches = 0, comparisons = 0;
    function automatic logic [3:0] pat(input logic [6:0] a);
        return a[3:0] ^ {1'b0, a[6:4]} ^ key[3:0];
    endfunction
    always #50 clk = ~clk;
    acof_output_framer i_dut (.clk(clk), .rst(rst), .out_port_clock({7'h00, link0}),
        .out_cell_start_in(fr_out & fr_oe), .out_cell_start_out(fr_out),
        .out_cell_start_oe(fr_oe), .out_port_nibble(nib), .out_port_nibble_oe(nib_oe),
        .port_map(24'hFAC680), .start_byte_addr(7'h00), .cell_valid(cv),
        .cell_data({8{pat(naddr[6:0])}}), .cell_taken(taken), .nib_addr(naddr),
        .cell_bus_mode(1'b0), .cell_bus_arbitration_out(7'h00),
        .cell_bus_arbitration_in(), .cell_bus_arbitration_oe(), .output_enable_n(oe_n),
        .control_output_enable_n(ctl_n), .control_enable_cfg(cfg),
        .control_outputs_oe(ctl_oe), .add_dummy_byte(add), .strip_dummy_byte(strip));
    acof_cell_sink i_sink (.run(run), .frame(fr_out[0] & fr_oe[0]), .nibble(nib[3:0]),
        .link_clk(link0));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // Pause stops the link clock mid-cell; no nibble may be lost
    task automatic send_cell(input logic s, input int pause);
        logic [3:0] q[$];
        int n;
        n = 0;
        @(negedge clk);
        strip = s;
        add = s;
        key = $random(seed);
        for (int a = 0; a < 108; a++)
            if (!(s && (a == 16 || a == 17))) q.push_back(pat(a[6:0]));
        i_sink.got.delete();
        i_sink.want = q.size();
        cv[0] = 1'b1;
        run = 1'b1;
        while (!taken[0] && n < 3000) begin
            @(negedge clk);
            n++;
            if (n == pause) run = 1'b0;
            if (n == pause + 40) run = 1'b1;
        end
        chk(taken[0], 1'b1);
        chk(nib[3:0], q[$]);
        chk(nib[7:4], q[$]);
        @(negedge clk);
        cv[0] = 1'b0;
        repeat (40) @(posedge clk);
        chk(i_sink.got.size(), q.size());
        foreach (q[i]) chk(i_sink.got[i], q[i]);
        chk(nib[7:4], nib[3:0]);
        run = 1'b0;
        $display("cell test done, strip %0d", s);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        {oe_n, ctl_n, cfg} = 3'h0;
        send_cell(1'b0, 0);
        send_cell(1'b1, 300);
        for (int c = 0; c < 8; c++) begin
            @(negedge clk);
            {oe_n, ctl_n, cfg} = c[2:0];
            repeat (6) @(posedge clk);
            chk(ctl_oe, c == 0);
            chk(nib_oe, {8{!c[2]}});
            chk(fr_oe & {8{c[2]}}, 8'h00);
        end
        $display("enable test done");
        end_of_test;
    end
    initial begin
        #(6000 * 100);
        mismatches++;
        end_of_test;
    end
endmodule // test_acof_output_framer
